// ===== hw/pccsc_map.svh
// Register offsets, field positions and reset values of the card status block.
`ifndef PCCSC_MAP_SVH
`define PCCSC_MAP_SVH

// Word offsets on the Wishbone bus, byte addresses.
`define PCCSC_OFS_FLAGS 4'h0
`define PCCSC_OFS_ENABLE 4'h4
`define PCCSC_OFS_GCR 4'h8

// Status change flag positions.
`define PCCSC_F_SOFT_CD 7
`define PCCSC_F_RSVD 6
`define PCCSC_F_IRQ 5
`define PCCSC_F_STSCHG 4
`define PCCSC_F_CD 3
`define PCCSC_F_READY 2
`define PCCSC_F_BATT_WARN 1
`define PCCSC_F_BATT_DEAD 0

// Enable register fields.
`define PCCSC_E_MODE_HI 6
`define PCCSC_E_MODE_LO 5
`define PCCSC_E_CD 3

// General control register fields.
`define PCCSC_G_CARD_TYPE 5
`define PCCSC_G_RSVD 4

// Reset values.
`define PCCSC_FLAGS_RST 8'h00
`define PCCSC_ENABLE_RST 8'h00
`define PCCSC_GCR_RST 8'h00

// Writable masks; reserved bits stay zero.
`define PCCSC_FLAGS_WMASK 8'hBF
`define PCCSC_GCR_WMASK 8'hEF

// Cycles after reset before pin edges are believed.
`define PCCSC_PRIME_W 3

`endif

// ===== hw/pccsc_pkg.sv
// Types shared by the card status change block.
package pccsc_pkg;

    // Card pins as seen at the socket; active-low pins end in _b.
    typedef struct packed {
        logic cd2_b;
        logic cd1_b;
        logic rdy_bsy;
        logic bvd2;
        logic bvd1;
        logic ireq_b;
    } pccsc_pins_t;

    // Card interrupt request mode, from the two mode bits.
    typedef enum logic [1:0] {
        PCCSC_IRQ_OFF = 2'b00,
        PCCSC_IRQ_LEVEL = 2'b01,
        PCCSC_IRQ_FALL = 2'b10,
        PCCSC_IRQ_RISE = 2'b11
    } pccsc_irq_mode_t;

    function automatic logic pccsc_fell(input logic prev, input logic cur);
        return prev & ~cur;
    endfunction

    function automatic logic pccsc_rose(input logic prev, input logic cur);
        return ~prev & cur;
    endfunction

endpackage

// ===== hw/pccsc_sync.sv
// Two-stage synchroniser for the card input pins.
module pccsc_sync #(
    parameter int W = 6
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // The first stage feeds only the second stage.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff <= '0;
            q_ff <= '0;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;

endmodule // pccsc_sync

// ===== hw/pccsc_top.sv
// Card status change flags with a Wishbone register interface.
// Overview of operation
// - Eight-bit flag register, zeroed by power-on reset, kept otherwise.
// - Bits 5..0 set only by hardware; software can set only bit 7.
// - Software card-detect bit raises card-detect interrupt when its enable is set.
// - Bit 6 reserved: reads zero, software writes zero.
// - I/O card: bit 5 sets on request matching selected pulse or level mode.
// - Pulse mode: bit 5 clears on written 0, written 1 ignored.
// - Level mode: bit 5 read-only, reads inverse of request pin.
// - I/O card: bit 4 sets on falling edge of status change pin.
// - Memory card: bits 5 and 4 read zero.
// - Bit 3 sets whenever card detect pins change, either card type.
// - Memory card: bit 2 sets on rising edge of ready/busy pin.
// - Memory card: bit 1 sets when battery pins show warning state.
// - Memory card: bit 0 sets when battery pins show dead state.
// - Battery flags re-evaluated whenever either battery pin changes.
// - I/O card: bits 2, 1 and 0 read zero.
// - Bits 4..0 clear on written 0; written 1 ignored.
// - Card type bit: 0 memory card, 1 I/O card.
// - A flag interrupts only when its enable bit is 1.
// - Mode bits: 00 off, 01 level low, 10 falling, 11 rising.
// - Write changing the mode bits clears the card interrupt flag.
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`include "pccsc_map.svh"

module pccsc_top (
    // Clock and power-on reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Card socket pins
    input wire pccsc_pkg::pccsc_pins_t card_pins,
    // Interrupt request
    output logic card_irq
);

    pccsc_pkg::pccsc_pins_t s_pins;
    pccsc_pkg::pccsc_pins_t prev_ff;
    logic [`PCCSC_PRIME_W-1:0] prime_ff;
    logic [7:0] flags_ff;
    logic [7:0] nxt_flags;
    logic [7:0] enable_ff;
    logic [7:0] gcr_ff;
    logic ack_ff;
    logic [31:0] dat_ff;

    // Pin synchronisation; edges compare the second stage with its delay.
    pccsc_sync #(
        .W($bits(pccsc_pkg::pccsc_pins_t))
    ) u_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .d(card_pins),
        .q(s_pins)
    );

    // Bus decode.
    wire req = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire wr_lane0 = req & wb_we_i & wb_sel_i[0];
    wire hit_flags = wb_adr_i == `PCCSC_OFS_FLAGS;
    wire hit_enable = wb_adr_i == `PCCSC_OFS_ENABLE;
    wire hit_gcr = wb_adr_i == `PCCSC_OFS_GCR;
    wire wr_flags = wr_lane0 & hit_flags;
    wire wr_enable = wr_lane0 & hit_enable;
    wire wr_gcr = wr_lane0 & hit_gcr;
    wire [7:0] wdata = wb_dat_i[7:0];

    // Card type and request mode.
    wire io_card = gcr_ff[`PCCSC_G_CARD_TYPE];
    wire mem_card = ~io_card;
    wire [1:0] mode_bits = enable_ff[`PCCSC_E_MODE_HI:`PCCSC_E_MODE_LO];
    pccsc_pkg::pccsc_irq_mode_t irq_mode;
    assign irq_mode = pccsc_pkg::pccsc_irq_mode_t'(mode_bits);
    wire [1:0] new_mode = wdata[`PCCSC_E_MODE_HI:`PCCSC_E_MODE_LO];
    wire mode_change = wr_enable & (new_mode != mode_bits);
    wire level_view = irq_mode == pccsc_pkg::PCCSC_IRQ_LEVEL
        || irq_mode == pccsc_pkg::PCCSC_IRQ_OFF;

    // Edge detection on synchronised pins, armed once the pipe is full.
    wire primed = prime_ff[`PCCSC_PRIME_W-1];
    wire cd_chg = primed & ((s_pins.cd1_b != prev_ff.cd1_b)
        | (s_pins.cd2_b != prev_ff.cd2_b));
    wire rdy_rise = primed
        & pccsc_pkg::pccsc_rose(prev_ff.rdy_bsy, s_pins.rdy_bsy);
    wire sts_fall = primed
        & pccsc_pkg::pccsc_fell(prev_ff.bvd1, s_pins.bvd1);
    wire bvd_chg = primed & ((s_pins.bvd1 != prev_ff.bvd1)
        | (s_pins.bvd2 != prev_ff.bvd2));
    wire ireq_fall = primed
        & pccsc_pkg::pccsc_fell(prev_ff.ireq_b, s_pins.ireq_b);
    wire ireq_rise = primed
        & pccsc_pkg::pccsc_rose(prev_ff.ireq_b, s_pins.ireq_b);
    wire batt_warn = ~s_pins.bvd2 & s_pins.bvd1;
    wire batt_dead = ~s_pins.bvd1;

    // Hardware set terms per flag.
    wire pulse_hit = (irq_mode == pccsc_pkg::PCCSC_IRQ_FALL && ireq_fall)
        || (irq_mode == pccsc_pkg::PCCSC_IRQ_RISE && ireq_rise);
    wire [5:0] set_vec;
    assign set_vec[`PCCSC_F_IRQ] = io_card & pulse_hit;
    assign set_vec[`PCCSC_F_STSCHG] = io_card & sts_fall;
    assign set_vec[`PCCSC_F_CD] = cd_chg;
    assign set_vec[`PCCSC_F_READY] = mem_card & rdy_rise;
    assign set_vec[`PCCSC_F_BATT_WARN] = mem_card & bvd_chg & batt_warn;
    assign set_vec[`PCCSC_F_BATT_DEAD] = mem_card & bvd_chg & batt_dead;

    // Software may only clear bits 5..0 and hardware sets win over a clear.
    // Flags of the other card type are held clear so a type switch starts
    // with a clean slate.
    wire [5:0] keep_vec = wr_flags ? wdata[5:0] : 6'h3F;
    wire [5:0] type_ok = io_card ? 6'h30 : 6'h0F;
    wire [5:0] mode_keep = mode_change ? 6'h1F : 6'h3F;
    always_comb begin
        nxt_flags = flags_ff;
        nxt_flags[5:0] = ((flags_ff[5:0] & keep_vec & mode_keep) | set_vec)
            & (type_ok | 6'h08);
        if (wr_flags) begin
            nxt_flags[`PCCSC_F_SOFT_CD] = wdata[`PCCSC_F_SOFT_CD];
        end
        nxt_flags[`PCCSC_F_RSVD] = 1'b0;
    end

    // Read view of the flag register.
    wire [7:0] flags_rd;
    assign flags_rd[`PCCSC_F_SOFT_CD] = flags_ff[`PCCSC_F_SOFT_CD];
    assign flags_rd[`PCCSC_F_RSVD] = 1'b0;
    assign flags_rd[`PCCSC_F_IRQ] = io_card
        & (level_view ? ~s_pins.ireq_b : flags_ff[`PCCSC_F_IRQ]);
    assign flags_rd[`PCCSC_F_STSCHG] = io_card
        & flags_ff[`PCCSC_F_STSCHG];
    assign flags_rd[2:0] = mem_card ? flags_ff[2:0] : 3'h0;
    assign flags_rd[`PCCSC_F_CD] = flags_ff[`PCCSC_F_CD];

    // Interrupt request: bits 4..0 gated by their own enables, bit 7 by the card-detect enable, bit 5 by a mode other than off.
    wire irq_en_req = irq_mode != pccsc_pkg::PCCSC_IRQ_OFF;
    wire [7:0] irq_terms;
    assign irq_terms[7] = flags_rd[`PCCSC_F_SOFT_CD]
        & enable_ff[`PCCSC_E_CD];
    assign irq_terms[6] = 1'b0;
    assign irq_terms[5] = flags_rd[`PCCSC_F_IRQ] & irq_en_req;
    assign irq_terms[4:0] = flags_rd[4:0] & enable_ff[4:0];
    assign card_irq = |irq_terms;

    // Read mux; unmapped words read zero.
    wire [7:0] rd_byte = hit_flags ? flags_rd
        : hit_enable ? enable_ff
        : hit_gcr ? gcr_ff
        : 8'h00;

    // Flag, enable and control registers; only power-on reset clears them.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_ff <= `PCCSC_FLAGS_RST;
            enable_ff <= `PCCSC_ENABLE_RST;
            gcr_ff <= `PCCSC_GCR_RST;
        end else begin
            flags_ff <= nxt_flags;
            if (wr_enable) begin
                enable_ff <= wdata;
            end
            if (wr_gcr) begin
                gcr_ff <= wdata & `PCCSC_GCR_WMASK;
            end
        end
    end

    // Pin history for edge detection.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_ff <= '0;
            prime_ff <= '0;
        end else begin
            prev_ff <= s_pins;
            prime_ff <= {prime_ff[`PCCSC_PRIME_W-2:0], 1'b1};
        end
    end

    // Wishbone answer one cycle after the request, read data registered.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= req;
            if (req && !wb_we_i) begin
                dat_ff <= {24'h00_0000, rd_byte};
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    property p_hw_only_set;
        @(posedge core_clk) disable iff (!rst_b)
        $rose(flags_ff[`PCCSC_F_CD]) |-> $past(set_vec[`PCCSC_F_CD]);
    endproperty
    a_hw_only_set: assert property (p_hw_only_set)
        else $error("card detect flag rose without a pin change");

    property p_soft_cd_irq;
        @(posedge core_clk) disable iff (!rst_b)
        (wr_flags && wdata[`PCCSC_F_SOFT_CD] && !wr_enable
            && enable_ff[`PCCSC_E_CD]) |=> card_irq;
    endproperty
    a_soft_cd_irq: assert property (p_soft_cd_irq)
        else $error("software card detect did not raise the interrupt");

    property p_rsvd_zero;
        @(posedge core_clk) disable iff (!rst_b)
        (wb_ack_o && hit_flags && !wb_we_i) |-> wb_dat_o[`PCCSC_F_RSVD] == 1'b0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved flag bit read as one");

    property p_pulse_set;
        @(posedge core_clk) disable iff (!rst_b)
        (io_card && pulse_hit && !wr_gcr)
            |=> flags_ff[`PCCSC_F_IRQ] ##1 flags_rd[`PCCSC_F_IRQ] || wr_flags
            || wr_enable || $past(wr_flags) || $past(wr_enable)
            || $past(wr_gcr);
    endproperty
    a_pulse_set: assert property (p_pulse_set)
        else $error("pulse request did not set the card interrupt flag");

    property p_clear_on_zero;
        @(posedge core_clk) disable iff (!rst_b)
        (wr_flags && !wdata[`PCCSC_F_STSCHG] && !set_vec[`PCCSC_F_STSCHG])
            |=> !flags_ff[`PCCSC_F_STSCHG];
    endproperty
    a_clear_on_zero: assert property (p_clear_on_zero)
        else $error("status change flag survived a written zero");

    property p_level_track;
        @(posedge core_clk) disable iff (!rst_b)
        (io_card && irq_mode == pccsc_pkg::PCCSC_IRQ_LEVEL)
            |-> flags_rd[`PCCSC_F_IRQ] == !s_pins.ireq_b;
    endproperty
    a_level_track: assert property (p_level_track)
        else $error("level mode flag does not follow the request pin");

    property p_mem_masks_io;
        @(posedge core_clk) disable iff (!rst_b)
        mem_card |-> flags_rd[5:4] == 2'b00;
    endproperty
    a_mem_masks_io: assert property (p_mem_masks_io)
        else $error("I/O flags visible with a memory card");

    property p_io_masks_mem;
        @(posedge core_clk) disable iff (!rst_b)
        io_card |-> flags_rd[2:0] == 3'b000;
    endproperty
    a_io_masks_mem: assert property (p_io_masks_mem)
        else $error("memory flags visible with an I/O card");

    property p_ready_rise;
        @(posedge core_clk) disable iff (!rst_b)
        (mem_card && rdy_rise && !wr_gcr) |=> flags_rd[`PCCSC_F_READY];
    endproperty
    a_ready_rise: assert property (p_ready_rise)
        else $error("ready rise did not set the ready change flag");

    property p_batt_warn;
        @(posedge core_clk) disable iff (!rst_b)
        (mem_card && bvd_chg && batt_warn && !wr_gcr)
            |=> flags_rd[`PCCSC_F_BATT_WARN] && !flags_ff[`PCCSC_F_RSVD];
    endproperty
    a_batt_warn: assert property (p_batt_warn)
        else $error("battery warning state not flagged");

    property p_mode_clear;
        @(posedge core_clk) disable iff (!rst_b)
        (mode_change && !set_vec[`PCCSC_F_IRQ]) |=> !flags_ff[`PCCSC_F_IRQ];
    endproperty
    a_mode_clear: assert property (p_mode_clear)
        else $error("mode change left the card interrupt flag set");

    property p_no_enable_no_irq;
        @(posedge core_clk) disable iff (!rst_b)
        (enable_ff == 8'h00) |-> !card_irq;
    endproperty
    a_no_enable_no_irq: assert property (p_no_enable_no_irq)
        else $error("interrupt raised with every enable clear");

    // Two low samples in a row, so the flops have been cleared even when the
    // falling edge of reset at time zero was missed.
    property p_reset_clear;
        @(posedge core_clk)
        !rst_b ##1 !rst_b |-> flags_ff == `PCCSC_FLAGS_RST && !card_irq;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("flags not cleared by power-on reset");

    property p_no_soft_set;
        @(posedge core_clk) disable iff (!rst_b)
        (wr_flags && set_vec == 6'h00)
            |=> (flags_ff[5:0] & ~$past(flags_ff[5:0])) == 6'h00;
    endproperty
    a_no_soft_set: assert property (p_no_soft_set)
        else $error("software write set a hardware flag");

    property p_card_type;
        @(posedge core_clk) disable iff (!rst_b)
        wr_gcr |=> io_card == $past(wdata[`PCCSC_G_CARD_TYPE]);
    endproperty
    a_card_type: assert property (p_card_type)
        else $error("card type bit did not follow the write");

    property p_cd_change;
        @(posedge core_clk) disable iff (!rst_b)
        cd_chg |=> flags_rd[`PCCSC_F_CD];
    endproperty
    a_cd_change: assert property (p_cd_change)
        else $error("card detect change not flagged");

    property p_sts_fall;
        @(posedge core_clk) disable iff (!rst_b)
        (io_card && sts_fall && !wr_gcr) |=> flags_rd[`PCCSC_F_STSCHG];
    endproperty
    a_sts_fall: assert property (p_sts_fall)
        else $error("status change fall not flagged");

    property p_batt_dead;
        @(posedge core_clk) disable iff (!rst_b)
        (mem_card && bvd_chg && batt_dead && !wr_gcr)
            |=> flags_rd[`PCCSC_F_BATT_DEAD];
    endproperty
    a_batt_dead: assert property (p_batt_dead)
        else $error("battery dead state not flagged");

    property p_pulse_keep;
        @(posedge core_clk) disable iff (!rst_b)
        (io_card && !level_view && flags_ff[`PCCSC_F_IRQ] && wr_flags
            && wdata[`PCCSC_F_IRQ]) |=> flags_ff[`PCCSC_F_IRQ];
    endproperty
    a_pulse_keep: assert property (p_pulse_keep)
        else $error("written one cleared the card interrupt flag");

    property p_cd_irq;
        @(posedge core_clk) disable iff (!rst_b)
        (flags_rd[`PCCSC_F_CD] && enable_ff[`PCCSC_E_CD]) |-> card_irq;
    endproperty
    a_cd_irq: assert property (p_cd_irq)
        else $error("enabled card detect flag raised no interrupt");

endmodule // pccsc_top

// ===== dv/pccsc_card_model.sv
// Socket-side model of the inserted card, owning the card pins.
module pccsc_card_model (
    // Clock
    input wire logic core_clk,
    // Pins toward the socket
    output pccsc_pkg::pccsc_pins_t card_pins
);
    timeunit 1ns;
    timeprecision 1ps;

    // Card present, busy, battery good, no request.
    initial card_pins = 6'h07;

    // Pins move just after an edge and hold far beyond the two-cycle minimum.
    // That way the synchroniser and the edge detector always see the change.
    task automatic apply(input logic [5:0] v);
        @(posedge core_clk);
        card_pins <= v;
        repeat (6) @(posedge core_clk);
    endtask

endmodule // pccsc_card_model

// ===== dv/test_pc_card_status_change_flags.sv
// Self-checking bench for the card status change flags.
`include "pccsc_map.svh"

module test_pc_card_status_change_flags;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [3:0] FL = `PCCSC_OFS_FLAGS;
    localparam logic [3:0] EN = `PCCSC_OFS_ENABLE;
    localparam logic [3:0] GC = `PCCSC_OFS_GCR;

    logic core_clk;
    logic rst_b;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [3:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic card_irq;
    pccsc_pkg::pccsc_pins_t card_pins;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;

    pccsc_top u_pccsc_top (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .card_pins(card_pins),
        .card_irq(card_irq)
    );

    pccsc_card_model u_pccsc_card_model (
        .core_clk(core_clk),
        .card_pins(card_pins)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic tally_and_finish();
        if (fails == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // A hang anywhere ends the run well after the sequence should be done.
    initial begin
        forever begin
            @(posedge core_clk);
            cycles++;
            if (cycles == 5000) begin
                fails++;
                tally_and_finish();
            end
        end
    end

    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One classic cycle; the request holds until ack is sampled high.
    task automatic wb(input logic we, input logic [3:0] adr,
                      input logic [7:0] wd, output logic [7:0] rd);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h000000, wd};
        // Only the bench timeout ends a wait that never sees ack.
        do begin
            @(posedge core_clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] r;
        wb(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input string nm, input logic [3:0] a,
                          input logic [7:0] e);
        logic [7:0] r;
        wb(1'b0, a, 8'h00, r);
        check(nm, r, e);
    endtask

    task automatic irq_chk(input logic e);
        check("card_irq", {7'h00, card_irq}, {7'h00, e});
    endtask

    task automatic pins(input logic [5:0] v);
        u_pccsc_card_model.apply(v);
    endtask

    task automatic t_reset_vals();
        rd_chk("flags", FL, 8'h00);
        rd_chk("enable", EN, 8'h00);
        rd_chk("gcr", GC, 8'h00);
        wr(4'hC, 8'hFF);
        rd_chk("unmapped", 4'hC, 8'h00);
        irq_chk(1'b0);
    endtask

    task automatic t_soft_cd();
        wr(FL, 8'hBF);
        rd_chk("flags", FL, 8'h80);
        irq_chk(1'b0);
        wr(EN, 8'h08);
        irq_chk(1'b1);
        wr(FL, 8'h00);
        rd_chk("flags", FL, 8'h00);
        irq_chk(1'b0);
    endtask

    task automatic t_mem_card();
        pins(6'h17);
        rd_chk("flags", FL, 8'h08);
        irq_chk(1'b1);
        pins(6'h1F);
        rd_chk("flags", FL, 8'h0C);
        pins(6'h1B);
        rd_chk("flags", FL, 8'h0E);
        pins(6'h1D);
        rd_chk("flags", FL, 8'h0F);
        wr(EN, 8'h00);
        irq_chk(1'b0);
        wr(EN, 8'h01);
        irq_chk(1'b1);
        pins(6'h1F);
        wr(FL, 8'h0E);
        rd_chk("flags", FL, 8'h0E);
        wr(FL, 8'h00);
        rd_chk("flags", FL, 8'h00);
    endtask

    task automatic t_io_card();
        wr(GC, 8'h20);
        rd_chk("gcr", GC, 8'h20);
        pins(6'h17);
        pins(6'h1F);
        rd_chk("flags", FL, 8'h00);
        wr(EN, 8'h10);
        pins(6'h1D);
        rd_chk("flags", FL, 8'h10);
        irq_chk(1'b1);
        pins(6'h1F);
        wr(FL, 8'h00);
        rd_chk("flags", FL, 8'h00);
    endtask

    task automatic t_irq_modes();
        wr(EN, 8'h20);
        pins(6'h1E);
        rd_chk("flags", FL, 8'h20);
        irq_chk(1'b1);
        wr(FL, 8'h00);
        rd_chk("flags", FL, 8'h20);
        pins(6'h1F);
        rd_chk("flags", FL, 8'h00);
        wr(EN, 8'h60);
        pins(6'h1E);
        rd_chk("flags", FL, 8'h00);
        pins(6'h1F);
        rd_chk("flags", FL, 8'h20);
        wr(FL, 8'h20);
        rd_chk("flags", FL, 8'h20);
        wr(EN, 8'h40);
        rd_chk("flags", FL, 8'h00);
        pins(6'h1E);
        rd_chk("flags", FL, 8'h20);
        wr(FL, 8'h00);
        rd_chk("flags", FL, 8'h00);
        wr(EN, 8'h00);
        rd_chk("flags", FL, 8'h20);
        irq_chk(1'b0);
        wr(GC, 8'h00);
        rd_chk("flags", FL, 8'h00);
    endtask

    task automatic t_second_reset();
        wr(FL, 8'h80);
        wr(EN, 8'h08);
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        rd_chk("flags", FL, 8'h00);
        rd_chk("enable", EN, 8'h00);
        irq_chk(1'b0);
    endtask

    initial begin
        rst_b = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 4'h0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h00000000;
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        // Pin edges are ignored while the input pipe primes.
        repeat (6) @(posedge core_clk);
        t_reset_vals();
        t_soft_cd();
        t_mem_card();
        t_io_card();
        t_irq_modes();
        t_second_reset();
        tally_and_finish();
    end

endmodule // test_pc_card_status_change_flags
